/* File: src/lxr_core.sv */
// light sensor back end: ranging, result bytes, threshold interrupt
// assumes a byte register port from a serial slave on clock_in
// and a converter count held valid at the end of each integration
//
// How it works
// - override clear: division and period come from autoranging
// - override set: division and period come from host writes
// - division bit 3: zero passes full current, one divides by eight
// - autoranging only picks 100, 200, 400 or 800 ms periods
// - period codes run 800 ms down to 6.25 ms by halving
// - periods under 100 ms only reachable under override
// - high byte holds exponent and mantissa top; low byte mantissa bottom
// - exponent 1111 reports over range
// - result bytes freeze at bus start and resume at stop
// - reading above upper limit past delay sets flag, pulls pin low
// - upper limit mantissa low nibble filled with ones
// - reading below lower limit past delay raises interrupt; zero nibble
// - delay is timer times 100 ms; zero fires at once
// - autorange divides above about 700 lux, lengthens period in dimness
// - result is four bit exponent and eight bit mantissa
// - flag clears on status read or on writing enable zero
// - continuous clear: one start per 800 ms; set: back to back
// - without override, division and period read back auto values
`timescale 1ns/1ps
`default_nettype none
module lxr_core #(
  parameter int TICK_CYCLES = lxr_pkg::TICK_CYCLES_DEF
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [15:0] adc_count_in,
  output logic             conv_run_out,
  output logic             current_divide_sel_out,
  output logic [2:0]       integration_period_code_out,
  output logic             int_pin_out,
  output logic             int_pin_oe_out
);
  import lxr_pkg::*;

  typedef enum logic {ST_WAIT, ST_INTEG} lxr_meas_e;

  logic [16:0] tick_cnt_r;
  logic        tick;
  logic        free_running_sample_r;
  logic        range_override_r;
  logic        man_cdr_r;
  logic [2:0]  man_code_r;
  logic        auto_cdr_r;
  logic [2:0]  auto_code_r;
  logic        eff_cdr;
  logic [2:0]  eff_code;
  logic        irq_enable_r;
  logic        irq_flag_r;
  logic [7:0]  upper_r;
  logic [7:0]  lower_r;
  logic [7:0]  delay_r;
  lxr_meas_e   state_r;
  logic [7:0]  frame_cnt_r;
  logic        meas_cdr_r;
  logic [2:0]  meas_code_r;
  logic [7:0]  integ_ticks;
  logic        integ_end;
  logic        frame_end;
  logic        meas_start;
  logic [3:0]  shamt;
  logic [25:0] total;
  logic [3:0]  new_exp;
  logic [7:0]  new_mant;
  logic [11:0] new_val;
  logic [11:0] shadow_r;
  logic [11:0] lux_r;
  logic        freeze_r;
  logic        bus_start;
  logic        bus_stop;
  logic [11:0] upper_full;
  logic [11:0] lower_full;
  logic        new_outside;
  logic        outside_r;
  logic        fired_r;
  logic [11:0] persist_cnt_r;
  logic [11:0] delay_ticks;
  logic        trigger;
  logic        wr_cfg;
  logic        wr_en;
  logic        rd_status;

  assign wr_cfg    = reg_wr_in && (reg_addr_in == ADDR_CONFIG);
  assign wr_en     = reg_wr_in && (reg_addr_in == ADDR_ENABLE);
  assign rd_status = reg_rd_in && (reg_addr_in == ADDR_STATUS);

  // =========================================
  // tick divider: one enable pulse per 6.25 ms
  assign tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end

  // =========================================
  // configuration register
  // writes in auto mode must not disturb the held manual values
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      free_running_sample_r <= CFG_RESET[CFG_FREE_BIT];
      range_override_r      <= CFG_RESET[CFG_OVR_BIT];
      man_cdr_r             <= CFG_RESET[CFG_CDR_BIT];
      man_code_r            <= CFG_RESET[2:0];
    end else if (wr_cfg) begin
      free_running_sample_r <= reg_wdata_in[CFG_FREE_BIT];
      range_override_r      <= reg_wdata_in[CFG_OVR_BIT];
      if (reg_wdata_in[CFG_OVR_BIT]) begin
        man_cdr_r  <= reg_wdata_in[CFG_CDR_BIT];
        man_code_r <= reg_wdata_in[2:0];
      end
    end
  end

  assign eff_cdr  = range_override_r ? man_cdr_r : auto_cdr_r;
  assign eff_code = range_override_r ? man_code_r : auto_code_r;

  // =========================================
  // threshold, delay and enable registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_enable_r <= 1'b0;
      upper_r      <= UPPER_RESET;
      lower_r      <= LOWER_RESET;
      delay_r      <= DELAY_RESET;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_ENABLE: irq_enable_r <= reg_wdata_in[IRQ_BIT];
        ADDR_UPPER:  upper_r      <= reg_wdata_in;
        ADDR_LOWER:  lower_r      <= reg_wdata_in;
        ADDR_DELAY:  delay_r      <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // =========================================
  // measurement sequencer
  // the range is latched at start so a mid-frame write cannot skew a reading
  assign integ_ticks = 8'(FRAME_TICKS) >> meas_code_r;
  assign integ_end   = (state_r == ST_INTEG) && tick && (frame_cnt_r + 8'h01 == integ_ticks);
  assign frame_end   = tick && (frame_cnt_r + 8'h01 == 8'(FRAME_TICKS));
  assign meas_start  = ((state_r == ST_INTEG) && integ_end && (free_running_sample_r || frame_end))
                       || ((state_r == ST_WAIT) && frame_end);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r     <= ST_WAIT;
      frame_cnt_r <= 8'(FRAME_TICKS - 1);
      meas_cdr_r  <= CFG_RESET[CFG_CDR_BIT];
      meas_code_r <= CFG_RESET[2:0];
    end else if (meas_start) begin
      state_r     <= ST_INTEG;
      frame_cnt_r <= '0;
      meas_cdr_r  <= eff_cdr;
      meas_code_r <= eff_code;
    end else if (integ_end) begin
      state_r     <= ST_WAIT;
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end else if (tick) begin
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end
  end

  // =========================================
  // scale the raw count by period and divider, then encode
  assign shamt = {1'b0, meas_code_r} + (meas_cdr_r ? DIV_SHIFT : 4'h0);
  assign total = {10'h000, adc_count_in} << shamt;

  lxr_float_enc u_enc (
    .value_in (total),
    .exp_out  (new_exp),
    .mant_out (new_mant)
  );

  assign new_val = {new_exp, new_mant};

  // =========================================
  // autoranging
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      auto_cdr_r  <= CFG_RESET[CFG_CDR_BIT];
      auto_code_r <= CFG_RESET[2:0];
    end else if (integ_end && !range_override_r) begin
      if (total >= DIV_ON_COUNT) begin
        auto_cdr_r <= 1'b1;
      end else if (total < DIV_OFF_COUNT) begin
        auto_cdr_r <= 1'b0;
      end
      if (adc_count_in >= RAW_HIGH && auto_code_r < AUTO_CODE_MAX) begin
        auto_code_r <= auto_code_r + 3'h1;
      end else if (adc_count_in < RAW_LOW && auto_code_r != 3'h0) begin
        auto_code_r <= auto_code_r - 3'h1;
      end
    end
  end

  // =========================================
  // result bytes; the shadow keeps the newest reading while frozen
  lxr_bus_cond u_bus (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .start_out (bus_start),
    .stop_out  (bus_stop)
  );

  // a stop between byte reads lets an update split the pair
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      freeze_r <= 1'b0;
    end else if (bus_start) begin
      freeze_r <= 1'b1;
    end else if (bus_stop) begin
      freeze_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      shadow_r <= '0;
    end else if (integ_end) begin
      shadow_r <= new_val;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      lux_r <= '0;
    end else if (!freeze_r) begin
      lux_r <= shadow_r;
    end
  end

  // =========================================
  // window compare and persistence
  // twelve bit compare orders exponent before mantissa
  assign upper_full  = {upper_r, UPPER_FILL};
  assign lower_full  = {lower_r, LOWER_FILL};
  assign new_outside = (new_val > upper_full) || (new_val < lower_full);
  assign delay_ticks = 12'(delay_r) * 12'(STEP_TICKS);
  assign trigger     = outside_r && !fired_r && irq_enable_r
                       && (persist_cnt_r >= delay_ticks);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      outside_r <= 1'b0;
    end else if (integ_end) begin
      outside_r <= new_outside;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      persist_cnt_r <= '0;
    end else if (integ_end && (!new_outside || !outside_r)) begin
      persist_cnt_r <= '0;
    end else if (tick && outside_r && persist_cnt_r != 12'hfff) begin
      persist_cnt_r <= persist_cnt_r + 12'h001;
    end
  end

  // one interrupt per excursion, rearmed when the reading returns inside
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fired_r <= 1'b0;
    end else if (!outside_r) begin
      fired_r <= 1'b0;
    end else if (trigger) begin
      fired_r <= 1'b1;
    end
  end

  // disabling wins over a same-cycle event; a status read does not
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_flag_r <= 1'b0;
    end else if (wr_en && !reg_wdata_in[IRQ_BIT]) begin
      irq_flag_r <= 1'b0;
    end else if (trigger) begin
      irq_flag_r <= 1'b1;
    end else if (rd_status) begin
      irq_flag_r <= 1'b0;
    end
  end

  // =========================================
  // read port, answered one cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_STATUS: reg_rdata_out <= {7'h00, irq_flag_r};
        ADDR_ENABLE: reg_rdata_out <= {7'h00, irq_enable_r};
        ADDR_CONFIG: reg_rdata_out <= {free_running_sample_r, range_override_r, 2'h0,
                                       eff_cdr, eff_code};
        ADDR_LUX_HI: reg_rdata_out <= lux_r[11:4];
        ADDR_LUX_LO: reg_rdata_out <= {4'h0, lux_r[3:0]};
        ADDR_UPPER:  reg_rdata_out <= upper_r;
        ADDR_LOWER:  reg_rdata_out <= lower_r;
        ADDR_DELAY:  reg_rdata_out <= delay_r;
        default:     reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // =========================================
  // converter and pin drive
  assign conv_run_out                = (state_r == ST_INTEG);
  assign current_divide_sel_out      = meas_cdr_r;
  assign integration_period_code_out = meas_code_r;
  assign int_pin_out                 = 1'b0;
  assign int_pin_oe_out              = irq_flag_r;

  // =========================================
  // checks
  chk_auto_code_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !range_override_r |-> (eff_code <= AUTO_CODE_MAX && eff_cdr == auto_cdr_r))
    else $error("auto range left its period set");

  chk_manual_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_cfg && reg_wdata_in[CFG_OVR_BIT] |=> eff_code == $past(reg_wdata_in[2:0])
    && eff_cdr == $past(reg_wdata_in[CFG_CDR_BIT]))
    else $error("manual range not taken");

  chk_freeze_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    freeze_r |=> $stable(lux_r))
    else $error("result moved while frozen");

  chk_resume_copy: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    bus_stop && !bus_start ##1 !freeze_r |=> lux_r == $past(shadow_r))
    else $error("result not resumed after stop");

  chk_irq_pin: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_pin_oe_out == irq_flag_r && !int_pin_out)
    else $error("pin does not follow flag");

  chk_enable_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !irq_enable_r |=> !$rose(irq_flag_r))
    else $error("flag rose while disabled");

  chk_read_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rd_status && !trigger |=> !irq_flag_r)
    else $error("status read did not clear flag");

  chk_zero_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    integ_end && new_outside && !outside_r && irq_enable_r && delay_r == 8'h00
    && !(reg_wr_in && reg_addr_in == ADDR_ENABLE) |-> ##[1:2] irq_flag_r)
    else $error("zero delay did not fire");

  chk_frame_spacing: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_start && !free_running_sample_r |-> frame_cnt_r == 8'(FRAME_TICKS - 1))
    else $error("start outside the 800 ms frame");

  chk_overrange: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    integ_end && (total >> 14) > 26'h00000ff |=> shadow_r[11:8] == EXP_OVER)
    else $error("over range not flagged");
endmodule
`default_nettype wire

/* File: src/lxr_pkg.sv */
// constants shared by the light sensor back end
// assumes a 20 MHz core clock and byte wide register access
`default_nettype none
package lxr_pkg;
  // =========================================
  // register map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_LUX_HI = 8'h03;
  localparam logic [7:0] ADDR_LUX_LO = 8'h04;
  localparam logic [7:0] ADDR_UPPER  = 8'h05;
  localparam logic [7:0] ADDR_LOWER  = 8'h06;
  localparam logic [7:0] ADDR_DELAY  = 8'h07;
  // =========================================
  // fields and reset values
  localparam int         CFG_FREE_BIT  = 7;
  localparam int         CFG_OVR_BIT   = 6;
  localparam int         CFG_CDR_BIT   = 3;
  localparam int         IRQ_BIT       = 0;
  localparam logic [7:0] CFG_RESET     = 8'h03;
  localparam logic [7:0] UPPER_RESET   = 8'hff;
  localparam logic [7:0] LOWER_RESET   = 8'h00;
  localparam logic [7:0] DELAY_RESET   = 8'hff;
  localparam logic [3:0] UPPER_FILL    = 4'hf;
  localparam logic [3:0] LOWER_FILL    = 4'h0;
  localparam logic [3:0] EXP_OVER      = 4'hf;
  localparam logic [2:0] AUTO_CODE_MAX = 3'h3;
  localparam logic [3:0] DIV_SHIFT     = 4'h3;
  // =========================================
  // timing: one tick is the shortest integration period
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_PERIOD_NS  = 6250000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FRAME_MS        = 800;
  localparam int STEP_MS         = 100;
  localparam int FRAME_TICKS     = FRAME_MS * 1000000 / TICK_PERIOD_NS;
  localparam int STEP_TICKS      = STEP_MS * 1000000 / TICK_PERIOD_NS;
  // =========================================
  // autoranging limits, in result lsb and raw converter counts
  localparam logic [25:0] DIV_ON_COUNT  = 26'h0003cc4;
  localparam logic [25:0] DIV_OFF_COUNT = 26'h00036b0;
  localparam logic [15:0] RAW_HIGH      = 16'hc000;
  localparam logic [15:0] RAW_LOW       = 16'h3000;
endpackage
`default_nettype wire

/* File: src/lxr_bus_cond.sv */
// start and stop detector on the serial bus wires
// assumes scl/sda are asynchronous pins, far slower than clock_in
`timescale 1ns/1ps
`default_nettype none
module lxr_bus_cond (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      start_out,
  output logic      stop_out
);
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;

  // =========================================
  // synchronisers; only stage two and later feed logic
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end

  // =========================================
  // sda moving while scl stays high marks start or stop
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      start_out <= 1'b0;
      stop_out  <= 1'b0;
    end else begin
      start_out <= scl_s2_r && scl_s3_r && !sda_s2_r && sda_s3_r;
      stop_out  <= scl_s2_r && scl_s3_r && sda_s2_r && !sda_s3_r;
    end
  end

  chk_start_stop_excl: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !(start_out && stop_out)) else $error("start and stop seen together");
endmodule
`default_nettype wire

/* File: src/lxr_float_enc.sv */
// converts a wide linear count into exponent and mantissa
// purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module lxr_float_enc (
  input  wire logic [25:0] value_in,
  output logic [3:0]       exp_out,
  output logic [7:0]       mant_out
);
  import lxr_pkg::*;

  // =========================================
  // smallest exponent whose shifted value fits eight bits
  always_comb begin
    exp_out  = EXP_OVER;
    mant_out = 8'hff;
    for (int e = 14; e >= 0; e--) begin
      if ((value_in >> e) < 26'h0000100) begin
        exp_out  = 4'(e);
        mant_out = 8'(value_in >> e);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/lxr_host_model.sv */
// far side model: bus host driving the serial wires and the register port
// assumes every task is entered just after a rising edge of clock_in
`timescale 1ns/1ps
`default_nettype none
module lxr_host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  output logic            scl_out,
  output logic            sda_out,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out
);
  // arbitrary bus address, no meaning beyond the bit pattern
  localparam logic [7:0] DEV_ADDR = 8'h5a;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // =========================================
  // register port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    step(1);
    wr_out <= 1'b0;
    wdata_out <= ~d;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    step(1);
    rd_out <= 1'b0;
    step(1);
    d = rdata_in;
  endtask
  // =========================================
  // serial wires, 400 ns bus clock, still between frames
  // also used as repeated start: no stop between paired reads
  task automatic bus_start;
    sda_out <= 1'b1;
    step(4);
    scl_out <= 1'b1;
    step(4);
    sda_out <= 1'b0;
    step(4);
    scl_out <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_out <= DEV_ADDR[i];
      step(4);
      scl_out <= 1'b1;
      step(4);
      scl_out <= 1'b0;
    end
    step(4);
  endtask
  task automatic bus_stop;
    sda_out <= 1'b0;
    step(4);
    scl_out <= 1'b1;
    step(4);
    sda_out <= 1'b1;
    step(4);
  endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the light sensor back end
// assumes TICK_CYCLES of 20, so 800 ms is 2560 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lxr_pkg::*;
  logic       clock_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       scl, sda, wr, rd, conv, div, pin, oe;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] code;
  logic [15:0] adc = 16'h0000;
  int         n_errors = 0;
  int         checks_done = 0;
  always #25 clock_in = ~clock_in;
  lxr_core #(.TICK_CYCLES(20)) u_lxr_core (.clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl),
    .sda_in(sda), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .adc_count_in(adc), .conv_run_out(conv), .current_divide_sel_out(div),
    .integration_period_code_out(code), .int_pin_out(pin), .int_pin_oe_out(oe));
  lxr_host_model u_lxr_host_model (.clock_in(clock_in), .rdata_in(rdata), .scl_out(scl),
    .sda_out(sda), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  // =========================================
  // helpers
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    u_lxr_host_model.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_lxr_host_model.rd(a, v);
    chk(v, e);
  endtask
  // waits out n whole measurements; bounded so a stuck converter fails
  task automatic meas(input int n);
    int i;
    repeat (n) begin
      i = 0;
      while (conv !== 1'b1 && i < 3000) begin @(posedge clock_in); i++; end
      while (conv !== 1'b0 && i < 6000) begin @(posedge clock_in); i++; end
      if (i >= 6000) chk(8'h01, 8'h00);
      repeat (4) @(posedge clock_in);
    end
  endtask
  // =========================================
  // scenarios
  task automatic t_reset;
    logic [7:0] tab [9] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    wrr(8'h08, 8'h5a);
    for (int a = 0; a < 9; a++) rdc(8'(a), tab[a]);
    chk({5'h0, code}, 8'h03);
    chk({7'h0, oe}, 8'h00);
  endtask
  task automatic t_result;
    adc <= 16'h0025;
    wrr(ADDR_CONFIG, 8'h43);
    meas(2);
    wrr(ADDR_LUX_HI, 8'h55);
    rdc(ADDR_LUX_HI, 8'h19);
    rdc(ADDR_LUX_LO, 8'h04);
    chk({4'h0, div, code}, 8'h03);
  endtask
  task automatic t_freeze;
    u_lxr_host_model.bus_start();
    adc <= 16'h0040;
    meas(1);
    rdc(ADDR_LUX_HI, 8'h19);
    u_lxr_host_model.bus_start();
    rdc(ADDR_LUX_LO, 8'h04);
    u_lxr_host_model.bus_stop();
    repeat (8) @(posedge clock_in);
    rdc(ADDR_LUX_HI, 8'h28);
    rdc(ADDR_LUX_LO, 8'h00);
  endtask
  task automatic t_upper;
    // reading 0x282: inside {0x28,f} only because of the filled nibble
    adc <= 16'h0041;
    wrr(ADDR_DELAY, 8'h00);
    wrr(ADDR_UPPER, 8'h28);
    wrr(ADDR_ENABLE, 8'h01);
    meas(1);
    chk({7'h0, oe}, 8'h00);
    wrr(ADDR_UPPER, 8'h1f);
    meas(1);
    chk({6'h0, pin, oe}, 8'h01);
    rdc(ADDR_STATUS, 8'h01);
    rdc(ADDR_STATUS, 8'h00);
    chk({7'h0, oe}, 8'h00);
  endtask
  task automatic t_lower;
    int i;
    wrr(ADDR_UPPER, 8'hff);
    wrr(ADDR_LOWER, 8'h28);
    meas(1);
    chk({7'h0, oe}, 8'h00);
    wrr(ADDR_LOWER, 8'h29);
    wrr(ADDR_DELAY, 8'h01);
    meas(1);
    chk({7'h0, oe}, 8'h00);
    i = 0;
    while (oe !== 1'b1 && i < 400) begin @(posedge clock_in); i++; end
    chk({7'h0, oe}, 8'h01);
    // sixteen ticks of 20 cycles after the reading went outside
    chk(8'(i >= 300 && i <= 330), 8'h01);
    wrr(ADDR_ENABLE, 8'h00);
    chk({7'h0, oe}, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
  endtask
  task automatic t_over;
    int i;
    adc <= 16'hffff;
    wrr(ADDR_CONFIG, 8'h4f);
    meas(1);
    i = 0;
    while (conv !== 1'b1 && i < 3000) begin @(posedge clock_in); i++; end
    i = 0;
    while (conv === 1'b1 && i < 100) begin @(posedge clock_in); i++; end
    // code 111 integrates for one tick of 20 cycles
    chk(8'(i), 8'h14);
    repeat (4) @(posedge clock_in);
    rdc(ADDR_LUX_HI, 8'hff);
    rdc(ADDR_LUX_LO, 8'h0f);
    chk({4'h0, div, code}, 8'h0f);
  endtask
  task automatic t_free_running_sample;
    int lows;
    int i;
    lows = 0;
    i = 0;
    wrr(ADDR_CONFIG, 8'hcf);
    // back to back readings keep conv high, so no end of measurement is awaited
    while (conv !== 1'b1 && i < 3000) begin @(posedge clock_in); i++; end
    repeat (100) begin
      @(posedge clock_in);
      if (conv !== 1'b1) lows++;
    end
    chk(8'(lows), 8'h00);
  endtask
  task automatic t_auto;
    int i;
    wrr(ADDR_CONFIG, 8'h0f);
    meas(5);
    rdc(ADDR_CONFIG, 8'h0b);
    wrr(ADDR_CONFIG, 8'h04);
    rdc(ADDR_CONFIG, 8'h0b);
    adc <= 16'h0010;
    // codes 3, 2, 1 end; an 800 ms reading then runs back to back and never drops conv
    meas(3);
    i = 0;
    while (conv !== 1'b1 && i < 3000) begin @(posedge clock_in); i++; end
    rdc(ADDR_CONFIG, 8'h00);
    chk({4'h0, div, code}, 8'h00);
  endtask
  // =========================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_result();
    t_freeze();
    t_upper();
    t_lower();
    t_over();
    t_free_running_sample();
    t_auto();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clock_in);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
